// >>> bkl_ctrl_pkg.sv
/*
  constants of the backlight control register bank: offsets, field positions,
  write masks, reset values, delay codes and timer states.
  assumes a single 25 MHz clock domain and 8-bit registers.
*/
package bkl_ctrl_pkg;
  // register offsets on the internal register port
  localparam logic [7:0] OFS_IRQ_EN  = 8'h01;  // irq_and_dummy_load_enable
  localparam logic [7:0] OFS_LEVEL   = 8'h02;  // backlight_level_control
  localparam logic [7:0] OFS_TIMERS  = 8'h03;  // backlight_timeout_timers
  // irq_and_dummy_load_enable fields
  localparam int BIT_DUMMY_LOAD      = 4;      // dummy_load_enable
  localparam int BIT_LIGHT_IRQ       = 3;      // light_compare_irq_enable
  localparam int BIT_OVP_IRQ         = 2;      // overvoltage_irq_enable
  // backlight_level_control fields
  localparam int POS_LEVEL           = 6;      // brightness_level_select lsb
  localparam int POS_CURVE           = 4;      // fade_curve_select lsb
  localparam int BIT_AUTO_ADJ        = 3;      // ambient_auto_adjust
  localparam int BIT_SOFT_OVP        = 2;      // soft_overvoltage_protect_enable
  localparam int BIT_FADE_BYPASS     = 1;      // fade_bypass
  // backlight_timeout_timers fields
  localparam int POS_OFF_DELAY       = 4;      // backlight_off_delay lsb
  localparam int POS_DIM_DELAY       = 0;      // backlight_dim_delay lsb
  // writable bits; the rest ignore writes and read zero
  localparam logic [7:0] MASK_IRQ_EN = 8'h1C;
  localparam logic [7:0] MASK_LEVEL  = 8'hFE;
  localparam logic [7:0] MASK_TIMERS = 8'hFF;
  // values after reset
  localparam logic [7:0] RST_IRQ_EN  = 8'h00;
  localparam logic [7:0] RST_LEVEL   = 8'h00;
  localparam logic [7:0] RST_TIMERS  = 8'h00;
  // brightness levels
  localparam logic [1:0] LVL_DAY     = 2'h0;   // L1
  localparam logic [1:0] LVL_OFFICE  = 2'h1;   // L2
  localparam logic [1:0] LVL_DARK    = 2'h2;   // L3
  // fade curves
  localparam logic [1:0] CURVE_LIN   = 2'h0;
  localparam logic [1:0] CURVE_SQR   = 2'h1;
  localparam logic [1:0] CURVE_CUB1  = 2'h2;
  localparam logic [1:0] CURVE_CUB2  = 2'h3;
  // dummy load thresholds on the backlight code
  localparam logic [6:0] LOAD_LIM_LIN = 7'h08; // below 8 under linear
  localparam logic [6:0] LOAD_LIM_SQR = 7'h20; // below 32 under square
  // delay code decode: short steps then long steps, in seconds
  localparam logic [3:0] DLY_LONG_FIRST = 4'h8;
  localparam int DLY_SHORT_BASE      = 5;      // code 1 -> 10 s
  localparam int DLY_SHORT_STEP      = 5;
  localparam int DLY_LONG_STEP       = 10;     // code 8 -> 50 s
  localparam int DLY_LONG_OFFSET     = 30;
  // one second at 25 MHz
  localparam int CLK_HZ              = 25000000;
  localparam int SECOND_S            = 1;
  localparam int CYC_PER_SECOND      = SECOND_S * CLK_HZ;
  // backlight timer states
  typedef enum logic [1:0] {
    BKL_IDLE = 2'b00,  // driver disabled
    BKL_RUN  = 2'b01,  // backlight lit, timers counting
    BKL_OFF  = 2'b10   // off delay expired
  } bkl_timer_e;
endpackage : bkl_ctrl_pkg

// >>> bkl_ctrl_regs.sv
/*
  backlight control register bank: interrupt enables and dummy load,
  level/curve/auto-adjust/protection/fade bypass, and the off and dim timers.
  assumes the serial interface decoder drives the register port on mclk and
  that comparator, overvoltage and driver enable signals are on mclk too.
*/
`timescale 1ns/1ps
module bkl_ctrl_regs #(
  parameter int CYC_PER_SEC = bkl_ctrl_pkg::CYC_PER_SECOND  // shorten in simulation
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       regWrEn,            // write strobe from serial decoder
  input  wire logic       regRdEn,            // read strobe from serial decoder
  input  wire logic [7:0] regAddr,            // register offset
  input  wire logic [7:0] regWrData,          // write data
  input  wire logic [6:0] backlightCode,      // present backlight sink code
  input  wire logic [1:0] ambientLevel,       // comparator verdict, level code
  input  wire logic       lightCompareTrip,   // comparator trip event
  input  wire logic       overvoltageTrip,    // overvoltage detect event
  input  wire logic       backlightDriverEnable, // mode register enable bit
  input  wire logic       hostDimSet,         // host writes dim bit to 1
  input  wire logic       hostDimClear,       // host writes dim bit to 0
  output logic [7:0]      regRdData,          // read data, one cycle after regRdEn
  output logic            dummyLoadOn,        // 1 mA dummy load switch
  output logic            lightCompareIrq,    // gated comparator interrupt pulse
  output logic            overvoltageIrq,     // gated overvoltage interrupt pulse
  output logic [1:0]      brightnessLevel,    // operating level in force
  output logic [1:0]      fadeCurve,          // fade transfer characteristic
  output logic            softOvpEnable,      // soft overvoltage protection
  output logic            fadeBypass,         // fade override
  output logic            backlightOn,        // backlight lit
  output logic            fadeOutApply,       // fade-out used when turning off
  output logic            dimActive           // dim mode active
);
  localparam int PW = $clog2(CYC_PER_SEC + 1);

  // stored registers
  logic [7:0] irqEn_r;                         // irq_and_dummy_load_enable
  logic [7:0] level_r;                         // backlight_level_control
  logic [7:0] timers_r;                        // backlight_timeout_timers
  logic [7:0] rdData_r;                        // registered read data
  logic       dummyLoad_r;                     // dummy load switch
  logic       lightIrq_r;                      // gated comparator pulse
  logic       ovpIrq_r;                        // gated overvoltage pulse
  logic       enPrev_r;                        // driver enable, last cycle
  logic       on_r;                            // backlight lit
  logic       dim_r;                           // dim active
  logic       dimTimed_r;                      // dim owned by the dim timer
  logic       fadeOut_r;                       // fade-out on turn-off, inverse of bypass
  logic [PW-1:0] prescale_r;                   // cycles into current second
  logic [6:0] offSecs_r;                       // seconds since enable
  logic [6:0] dimSecs_r;                       // seconds since enable
  bkl_ctrl_pkg::bkl_timer_e state_r;           // timer state
  bkl_ctrl_pkg::bkl_timer_e state_nxt;

  // delay code to seconds
  function automatic logic [6:0] bkl_decode(input logic [3:0] code);
    logic [6:0] secs;
    secs = 7'h00;
    if (code == 4'h0)
      secs = 7'h00;
    else if (code < bkl_ctrl_pkg::DLY_LONG_FIRST)
      secs = 7'(bkl_ctrl_pkg::DLY_SHORT_BASE + bkl_ctrl_pkg::DLY_SHORT_STEP * int'(code));
    else
      secs = 7'(bkl_ctrl_pkg::DLY_LONG_STEP * int'(code) - bkl_ctrl_pkg::DLY_LONG_OFFSET);
    return secs;
  endfunction : bkl_decode

  // address decode
  wire selIrq    = (regAddr == bkl_ctrl_pkg::OFS_IRQ_EN);
  wire selLevel  = (regAddr == bkl_ctrl_pkg::OFS_LEVEL);
  wire selTimers = (regAddr == bkl_ctrl_pkg::OFS_TIMERS);

  // fields
  wire [1:0] curve     = level_r[bkl_ctrl_pkg::POS_CURVE +: 2];
  wire [3:0] offCode   = timers_r[bkl_ctrl_pkg::POS_OFF_DELAY +: 4];
  wire [3:0] dimCode   = timers_r[bkl_ctrl_pkg::POS_DIM_DELAY +: 4];
  wire [6:0] offLimit  = bkl_decode(offCode);
  wire [6:0] dimLimit  = bkl_decode(dimCode);

  // comparator verdict clamped to the three defined levels
  wire [1:0] ambLevel  = (ambientLevel > bkl_ctrl_pkg::LVL_DARK) ? bkl_ctrl_pkg::LVL_DARK : ambientLevel;

  // level register next value: host bits masked, level field owned by auto-adjust
  wire [7:0] hostLevel = regWrData & bkl_ctrl_pkg::MASK_LEVEL;
  wire [7:0] levelWr   = (regWrEn && selLevel) ? hostLevel : level_r;
  wire       autoNext  = levelWr[bkl_ctrl_pkg::BIT_AUTO_ADJ];
  wire [1:0] lvlHost   = (levelWr[bkl_ctrl_pkg::POS_LEVEL +: 2] > bkl_ctrl_pkg::LVL_DARK)
                         ? level_r[bkl_ctrl_pkg::POS_LEVEL +: 2] : levelWr[bkl_ctrl_pkg::POS_LEVEL +: 2];
  wire [1:0] lvlNext   = autoNext ? ambLevel : lvlHost;
  wire [7:0] level_nxt = {lvlNext, levelWr[5:0]};

  // dummy load threshold per curve
  wire loadLin   = (curve == bkl_ctrl_pkg::CURVE_LIN) && (backlightCode < bkl_ctrl_pkg::LOAD_LIM_LIN);
  wire loadSqr   = (curve == bkl_ctrl_pkg::CURVE_SQR) && (backlightCode < bkl_ctrl_pkg::LOAD_LIM_SQR);
  wire load_nxt  = irqEn_r[bkl_ctrl_pkg::BIT_DUMMY_LOAD] && (loadLin || loadSqr);

  // read mux
  wire [7:0] rdMux = selIrq ? irqEn_r : selLevel ? level_r : selTimers ? timers_r : 8'h00;

  // timer events
  wire enRise    = backlightDriverEnable && !enPrev_r;
  wire secTick   = (prescale_r == PW'(CYC_PER_SEC - 1));
  wire offExpire = (state_r == bkl_ctrl_pkg::BKL_RUN) && (offLimit != 7'h00) && (offSecs_r >= offLimit);
  wire dimExpire = (state_r == bkl_ctrl_pkg::BKL_RUN) && dimTimed_r && (dimSecs_r >= dimLimit);

  // timer state transitions
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bkl_ctrl_pkg::BKL_IDLE: begin
        if (enRise) state_nxt = bkl_ctrl_pkg::BKL_RUN;           // start timers
      end
      bkl_ctrl_pkg::BKL_RUN: begin
        if (!backlightDriverEnable) state_nxt = bkl_ctrl_pkg::BKL_IDLE;
        else if (offExpire) state_nxt = bkl_ctrl_pkg::BKL_OFF;
      end
      bkl_ctrl_pkg::BKL_OFF: begin
        if (!backlightDriverEnable) state_nxt = bkl_ctrl_pkg::BKL_IDLE;
      end
      default: state_nxt = bkl_ctrl_pkg::BKL_IDLE;
    endcase
  end

  // register writes
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqEn_r  <= bkl_ctrl_pkg::RST_IRQ_EN;
      level_r  <= bkl_ctrl_pkg::RST_LEVEL;
      timers_r <= bkl_ctrl_pkg::RST_TIMERS;
      // fade-out follows the reset value of the bypass bit
      fadeOut_r <= !bkl_ctrl_pkg::RST_LEVEL[bkl_ctrl_pkg::BIT_FADE_BYPASS];
    end else begin
      if (regWrEn && selIrq) irqEn_r <= regWrData & bkl_ctrl_pkg::MASK_IRQ_EN;
      level_r <= level_nxt;
      // registered beside the level register so it moves in the same cycle as bypass
      fadeOut_r <= !level_nxt[bkl_ctrl_pkg::BIT_FADE_BYPASS];
      if (regWrEn && selTimers) timers_r <= regWrData & bkl_ctrl_pkg::MASK_TIMERS;
    end
  end

  // read data, dummy load and gated interrupt pulses
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdData_r    <= 8'h00;
      dummyLoad_r <= 1'b0;
      lightIrq_r  <= 1'b0;
      ovpIrq_r    <= 1'b0;
    end else begin
      if (regRdEn) rdData_r <= rdMux;
      dummyLoad_r <= load_nxt;
      lightIrq_r  <= lightCompareTrip && irqEn_r[bkl_ctrl_pkg::BIT_LIGHT_IRQ];
      ovpIrq_r    <= overvoltageTrip && irqEn_r[bkl_ctrl_pkg::BIT_OVP_IRQ];
    end
  end

  // seconds prescaler and elapsed counters, restarted on enable
  always_ff @(posedge mclk) begin
    if (!rstn || enRise || state_r != bkl_ctrl_pkg::BKL_RUN) begin
      prescale_r <= '0;
      offSecs_r  <= 7'h00;
      dimSecs_r  <= 7'h00;
    end else begin
      prescale_r <= secTick ? '0 : prescale_r + PW'(1);
      if (secTick && offSecs_r != 7'h7F) offSecs_r <= offSecs_r + 7'h01;
      if (secTick && dimSecs_r != 7'h7F) dimSecs_r <= dimSecs_r + 7'h01;
    end
  end

  // timer state, backlight on and dim ownership
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r    <= bkl_ctrl_pkg::BKL_IDLE;
      enPrev_r   <= 1'b0;
      on_r       <= 1'b0;
      dim_r      <= 1'b0;
      dimTimed_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      enPrev_r <= backlightDriverEnable;
      on_r     <= (state_nxt == bkl_ctrl_pkg::BKL_RUN);
      if (hostDimSet) begin
        // manual dim holds until the host clears it or an enable rise with a nonzero dim code hands it to the dim timer; set wins over expiry
        dim_r      <= 1'b1;
        dimTimed_r <= 1'b0;
      end else if (hostDimClear) begin
        dim_r      <= 1'b0;
        dimTimed_r <= 1'b0;
      end else if (enRise && dimCode != 4'h0) begin
        dim_r      <= 1'b1;
        dimTimed_r <= 1'b1;
      end else if (dimExpire || (dimTimed_r && state_nxt == bkl_ctrl_pkg::BKL_IDLE)) begin
        dim_r      <= 1'b0;
        dimTimed_r <= 1'b0;
      end
    end
  end

  // outputs straight from flip-flops
  assign regRdData       = rdData_r;
  assign dummyLoadOn     = dummyLoad_r;
  assign lightCompareIrq = lightIrq_r;
  assign overvoltageIrq  = ovpIrq_r;
  assign brightnessLevel = level_r[bkl_ctrl_pkg::POS_LEVEL +: 2];
  assign fadeCurve       = level_r[bkl_ctrl_pkg::POS_CURVE +: 2];
  assign softOvpEnable   = level_r[bkl_ctrl_pkg::BIT_SOFT_OVP];
  assign fadeBypass      = level_r[bkl_ctrl_pkg::BIT_FADE_BYPASS];
  assign backlightOn     = on_r;
  assign fadeOutApply    = fadeOut_r;
  assign dimActive       = dim_r;
endmodule : bkl_ctrl_regs

// >>> bkl_ctrl_properties.sv
/*
  concurrent checks on the ports of the backlight register bank.
  assumes a bind onto bkl_ctrl_regs and the single mclk domain.
*/
`timescale 1ns/1ps
module bkl_ctrl_properties (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [6:0] backlightCode,
  input wire logic       lightCompareTrip,
  input wire logic       overvoltageTrip,
  input wire logic       backlightDriverEnable,
  input wire logic       hostDimSet,
  input wire logic [7:0] regRdData,
  input wire logic       dummyLoadOn,
  input wire logic       lightCompareIrq,
  input wire logic       overvoltageIrq,
  input wire logic [1:0] brightnessLevel,
  input wire logic [1:0] fadeCurve,
  input wire logic       fadeBypass,
  input wire logic       backlightOn,
  input wire logic       fadeOutApply,
  input wire logic       dimActive
);
  wire  wrIrq = regWrEn && regAddr == 8'h01;  // host write to the enables
  wire  wrLvl = regWrEn && regAddr == 8'h02;  // host write to level control
  logic ldEn_r;                               // shadow of dummy_load_enable
  logic auto_r;                               // shadow of ambient_auto_adjust
  // shadows follow host writes so the checks know the bits in force
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ldEn_r <= 1'b0;
      auto_r <= 1'b0;
    end else begin
      if (wrIrq) ldEn_r <= regWrData[4];
      if (wrLvl) auto_r <= regWrData[3];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_rd_hole; regRdEn && (regAddr == 8'h00 || regAddr > 8'h03); endsequence
  sequence s_en_rise; !backlightDriverEnable ##1 backlightDriverEnable; endsequence
  property p_rd_hole; s_rd_hole |=> regRdData == 8'h00; endproperty
  property p_lirq; lightCompareIrq |-> $past(lightCompareTrip); endproperty
  property p_oirq; overvoltageIrq |-> $past(overvoltageTrip); endproperty
  property p_wr_lvl; wrLvl && !regWrData[3] && regWrData[7:6] != 2'h3
    |=> brightnessLevel == $past(regWrData[7:6]) && fadeCurve == $past(regWrData[5:4]); endproperty
  property p_manual; !auto_r && !$past(auto_r) && !$past(wrLvl) |-> $stable(brightnessLevel); endproperty
  property p_fade; fadeOutApply == !fadeBypass; endproperty
  property p_dummy; dummyLoadOn == $past(ldEn_r && ((fadeCurve == 2'h0 && backlightCode < 7'h08)
    || (fadeCurve == 2'h1 && backlightCode < 7'h20))); endproperty
  property p_on; s_en_rise |=> backlightOn; endproperty
  property p_off; !backlightDriverEnable |=> !backlightOn; endproperty
  property p_dimset; hostDimSet |=> dimActive; endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  a_lirq: assert property (p_lirq) else $error("light irq without trip");
  a_oirq: assert property (p_oirq) else $error("overvoltage irq without trip");
  a_wr_lvl: assert property (p_wr_lvl) else $error("level or curve not taken");
  a_manual: assert property (p_manual) else $error("level moved without write");
  a_fade: assert property (p_fade) else $error("fade-out not inverse of bypass");
  a_dummy: assert property (p_dummy) else $error("dummy load wrong");
  a_on: assert property (p_on) else $error("backlight not lit on enable");
  a_off: assert property (p_off) else $error("backlight lit while disabled");
  a_dimset: assert property (p_dimset) else $error("manual dim not set");
endmodule : bkl_ctrl_properties

// >>> bkl_ctrl_host.sv
/*
  host model: drives the register port and the driver enable bit.
  assumes one-cycle strobes sampled on the rising mclk edge.
*/
`timescale 1ns/1ps
module bkl_ctrl_host (
  input wire logic       mclk,
  input wire logic [7:0] regRdData,
  output logic           regWrEn,
  output logic           regRdEn,
  output logic [7:0]     regAddr,
  output logic [7:0]     regWrData,
  output logic           backlightDriverEnable
);
  // idle port at time zero
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    backlightDriverEnable = 1'b0;
  end
  // one write, held until the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
    #1;
  endtask : wr
  // one read, data taken after the edge that samples the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  // mode register driver enable bit
  task automatic en(input logic v);
    @(posedge mclk);
    backlightDriverEnable <= v;
    @(posedge mclk);
    #1;
  endtask : en
endmodule : bkl_ctrl_host

// >>> test_backlight_control_registers.sv
/*
  self-checking bench of the backlight register bank with a host model.
  assumes the timers shortened to 10 cycles per second.
*/
`timescale 1ns/1ps
module test_backlight_control_registers;
  localparam int CPS = 10;  // cycles per second in simulation
  logic       mclk, rstn, regWrEn, regRdEn, lightCompareTrip, overvoltageTrip, hostDimSet, hostDimClear;
  logic       backlightDriverEnable, dummyLoadOn, lightCompareIrq, overvoltageIrq, softOvpEnable;
  logic       fadeBypass, backlightOn, fadeOutApply, dimActive;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic [6:0] backlightCode;
  logic [1:0] ambientLevel, brightnessLevel, fadeCurve;
  int         mismatches, check_count;
  always #20 mclk = ~mclk;
  bkl_ctrl_regs #(.CYC_PER_SEC(CPS)) i_bkl_ctrl_regs (.mclk(mclk), .rstn(rstn), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .backlightCode(backlightCode),
    .ambientLevel(ambientLevel), .lightCompareTrip(lightCompareTrip), .overvoltageTrip(overvoltageTrip),
    .backlightDriverEnable(backlightDriverEnable), .hostDimSet(hostDimSet), .hostDimClear(hostDimClear),
    .regRdData(regRdData), .dummyLoadOn(dummyLoadOn), .lightCompareIrq(lightCompareIrq),
    .overvoltageIrq(overvoltageIrq), .brightnessLevel(brightnessLevel), .fadeCurve(fadeCurve),
    .softOvpEnable(softOvpEnable), .fadeBypass(fadeBypass), .backlightOn(backlightOn),
    .fadeOutApply(fadeOutApply), .dimActive(dimActive));
  bkl_ctrl_host host (.mclk(mclk), .regRdData(regRdData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .backlightDriverEnable(backlightDriverEnable));
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // reset values, writable masks, unmapped offset
  task t_regs;
    logic [7:0] a [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
    logic [7:0] d [4] = '{8'hFF, 8'hF7, 8'hFF, 8'h55};
    logic [7:0] e [4] = '{8'h1C, 8'h36, 8'hFF, 8'h00};
    for (int i = 0; i < 4; i++) begin
      host.rd(a[i], rdv);
      chk(rdv, 8'h00);
      host.wr(a[i], d[i]);
      host.rd(a[i], rdv);
      chk(rdv, e[i]);
    end
    host.wr(8'h03, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  // every level, curve and control bit reaches its output
  task t_fields;
    logic [1:0] lv, cv;
    for (int i = 0; i < 12; i++) begin
      lv = 2'(i % 3);
      cv = 2'(i % 4);
      host.wr(8'h02, {lv, cv, 1'b0, i[0], i[1], 1'b0});
      chk({brightnessLevel, fadeCurve, 4'h0}, {lv, cv, 4'h0});
      chk({5'h00, softOvpEnable, fadeBypass, fadeOutApply}, {5'h00, i[0], i[1], ~i[1]});
    end
    host.wr(8'h02, 8'hC0);
    chk({6'h00, brightnessLevel}, 8'h02);
    $display("t_fields done");
  endtask : t_fields
  // trips pass to the interrupt only when enabled, for one cycle
  task t_irq;
    for (int k = 0; k < 2; k++) begin
      host.wr(8'h01, k ? 8'h0C : 8'h00);
      @(posedge mclk) {lightCompareTrip, overvoltageTrip} <= 2'h3;
      @(posedge mclk) {lightCompareTrip, overvoltageTrip} <= 2'h0;
      #1 chk({6'h00, lightCompareIrq, overvoltageIrq}, k ? 8'h03 : 8'h00);
      cyc(1);
      chk({6'h00, lightCompareIrq, overvoltageIrq}, 8'h00);
    end
    $display("t_irq done");
  endtask : t_irq
  // auto-adjust owns the level; manual mode ignores the comparators
  task t_auto;
    host.wr(8'h02, 8'h48);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk) ambientLevel <= 2'(k);
      cyc(3);
      chk({6'h00, brightnessLevel}, k == 3 ? 8'h02 : 8'(k));
    end
    host.wr(8'h02, 8'h40);
    @(posedge mclk) ambientLevel <= 2'h0;
    cyc(3);
    chk({6'h00, brightnessLevel}, 8'h01);
    $display("t_auto done");
  endtask : t_auto
  // dummy load thresholds at each boundary code
  task t_dummy;
    logic [1:0] cv [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
    logic [6:0] cd [5] = '{7'h07, 7'h08, 7'h1F, 7'h20, 7'h00};
    logic [4:0] ex = 5'h05;
    host.wr(8'h01, 8'h10);
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h02, {2'h0, cv[i], 4'h0});
      @(posedge mclk) backlightCode <= cd[i];
      cyc(3);
      chk({7'h00, dummyLoadOn}, {7'h00, ex[i]});
    end
    host.wr(8'h02, 8'h00);
    host.wr(8'h01, 8'h00);
    cyc(2);
    chk({7'h00, dummyLoadOn}, 8'h00);
    $display("t_dummy done");
  endtask : t_dummy
  // off and dim delays, short and long steps, relight after enable toggles
  task t_timers;
    logic [7:0] tc [2] = '{8'h21, 8'h80};
    int osec [2] = '{15, 50};
    int dsec [2] = '{10, 0};
    for (int e = 0; e < 2; e++) begin
      host.wr(8'h03, tc[e]);
      host.en(1'b1);
      cyc(1);
      chk({6'h00, backlightOn, dimActive}, {6'h00, 1'b1, dsec[e] != 0});
      for (int n = 3; n <= osec[e] * CPS + 5; n++) begin
        cyc(1);
        if (dsec[e] != 0 && n == dsec[e] * CPS - 4) chk({7'h00, dimActive}, 8'h01);
        if (dsec[e] != 0 && n == dsec[e] * CPS + 4) chk({7'h00, dimActive}, 8'h00);
        if (n == osec[e] * CPS - 4) chk({7'h00, backlightOn}, 8'h01);
        if (n == osec[e] * CPS + 4) chk({7'h00, backlightOn}, 8'h00);
      end
      host.en(1'b0);
    end
    $display("t_timers done");
  endtask : t_timers
  // manual dim held until cleared; disable turns the backlight off
  task t_dim;
    @(posedge mclk) hostDimSet <= 1'b1;
    @(posedge mclk) hostDimSet <= 1'b0;
    cyc(5);
    chk({7'h00, dimActive}, 8'h01);
    @(posedge mclk) hostDimClear <= 1'b1;
    @(posedge mclk) hostDimClear <= 1'b0;
    cyc(2);
    chk({7'h00, dimActive}, 8'h00);
    host.en(1'b1);
    host.en(1'b0);
    chk({7'h00, backlightOn}, 8'h00);
    $display("t_dim done");
  endtask : t_dim
  // main sequence after six reset cycles
  initial begin
    {mclk, rstn, lightCompareTrip, overvoltageTrip, hostDimSet, hostDimClear} = 6'h00;
    {backlightCode, ambientLevel, mismatches, check_count} = '0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_fields();
    t_irq();
    t_auto();
    t_dummy();
    t_timers();
    t_dim();
    results();
  end
  // watchdog: about fifteen times the expected run of some 820 cycles
  initial begin
    #500000;
    mismatches++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end
endmodule : test_backlight_control_registers
bind bkl_ctrl_regs bkl_ctrl_properties i_bkl_ctrl_properties (.mclk(mclk), .rstn(rstn), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .backlightCode(backlightCode),
  .lightCompareTrip(lightCompareTrip), .overvoltageTrip(overvoltageTrip), .hostDimSet(hostDimSet),
  .backlightDriverEnable(backlightDriverEnable), .regRdData(regRdData), .dummyLoadOn(dummyLoadOn),
  .lightCompareIrq(lightCompareIrq), .overvoltageIrq(overvoltageIrq), .brightnessLevel(brightnessLevel),
  .fadeCurve(fadeCurve), .fadeBypass(fadeBypass), .backlightOn(backlightOn), .fadeOutApply(fadeOutApply),
  .dimActive(dimActive));
